// ==== hw/shp_spi_host_port_defines.svh ====
// Purpose: Named constants of the SPI host port with interrupt status
// Assumes: Byte-wide register space reached over the serial port
// Notes:   Included by the port module only
`ifndef SHP_SPI_HOST_PORT_DEFINES_SVH
`define SHP_SPI_HOST_PORT_DEFINES_SVH

// First byte fields, last bit index, filler byte and address step
`define SHP_HDR_TYPE_BIT    3'h7
`define SHP_HDR_DIR_BIT     3'h0
`define SHP_BIT_LAST        3'h7
`define SHP_BYTE_ZERO       8'h00
`define SHP_ADDR_STEP       8'h01

// Address map
`define SHP_FIFO_ADDR       8'hFF
`define SHP_MASK_BASE       8'h90
`define SHP_STATUS_BASE     8'hFA
`define SHP_IRQ_BYTES       8'h04

// Interrupt bits 0..21, 29 and 30 exist; the rest read as zero
`define SHP_IRQ_VALID       32'h603F_FFFF
`define SHP_IRQ_RESET       32'h0000_0000
`define SHP_MASK_RESET      32'h0000_0000

// Pin selection code that routes the interrupt request to a pin
`define SHP_GPIO_SEL_IRQ    5'h00
`define SHP_GPIO_COUNT      4

`endif

// ==== hw/shp_pkg.sv ====
// Purpose: Types of the SPI host port
// Assumes: Constants live in the defines header
// Notes:   Phase of the current serial transaction
package shp_pkg;

    typedef enum logic [1:0] {
        SHP_PH_HEADER,
        SHP_PH_ADDR,
        SHP_PH_DATA,
        SHP_PH_DONE
    } shp_phase_type;

endpackage

// ==== hw/shp_spi_host_port.sv ====
// Purpose: Four-wire SPI slave host port with interrupt status and mask
// Assumes: Serial clock at most 10 MHz, core clock 100 MHz, pins sampled twice
// Notes:   Read data is fetched ahead, so a burst read consumes one extra byte
`timescale 1ns/1ps
`include "shp_spi_host_port_defines.svh"

// Overview of operation
// R1: Host is master, drives select and clock
// R2: Clock idles low; sample rising, change falling
// R3: Output tristated while chip select is high
// R4: All bytes travel most significant bit first
// R5: First byte MSB: 0 address, 1 command
// R6: First byte LSB: 1 read, 0 write
// R7: Host sends zero in other header bits
// R8: Two state status bytes shift out first
// R9: Burst access increments address each data byte
// R10: Address 0xFF reaches data FIFO, bursts step; this port keeps 0xFF through a burst
// R11: FIFO read drains RX, write fills TX
// R12: Port works in every state including sleep
// R13: Host waits 2 us, clock under 10 MHz
// R14: Bits 0-2: RX ready, discarded, TX sent
// R15: Bits 3-6: retries, CRC, FIFO flow errors
// R16: Bits 7-10: FIFO almost full and empty
// R17: Bits 11-14: backoff, preamble, sync, carrier
// R18: Bits 15, 16, 18: wake-up, ready, battery
// R19: Bits 17, 19-21, 29, 30: other device events
// R20: Interrupt request appears on a configured pin
// R21: Events set bits; reading clears them
// R22: Mask bit zero blocks that event
// R23: Pin selection zero carries active-low request
// R24: Request held while masked status pending
// R25: Status bits stay set until read
module shp_spi_host_port (
    // Clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        reset_i,
    // Serial pins
    input  wire logic        spi_sclk_i,
    input  wire logic        spi_chip_select_low_i,
    input  wire logic        spi_mosi_i,
    output logic             spi_miso_o,
    output logic             spi_miso_oe_o,
    // Device state shown during the header and the second byte
    input  wire logic [15:0] device_state_status_i,
    // Register space
    output logic [7:0]       reg_addr_o,
    output logic [7:0]       reg_wdata_o,
    output logic             reg_wr_o,
    output logic             reg_rd_o,
    input  wire logic [7:0]  reg_rdata_i,
    // Data FIFOs
    output logic             tx_fifo_wr_o,
    output logic             rx_fifo_rd_o,
    input  wire logic [7:0]  rx_fifo_rdata_i,
    // Command strokes
    output logic [7:0]       cmd_code_o,
    output logic             cmd_valid_o,
    // Interrupt events and pins
    input  wire logic [31:0] irq_event_i,
    input  wire logic [19:0] gpio_sel_i,
    output logic [3:0]       gpio_o
);

    logic [2:0]            sclk_q;
    logic [1:0]            csn_q;
    logic [1:0]            mosi_q;
    logic                  act_q;
    logic [2:0]            bit_q;
    logic [7:0]            rx_q;
    logic [7:0]            tx_q;
    logic [7:0]            next_q;
    logic                  done_q;
    logic                  fetch_q;
    logic                  wr_step_q;
    logic                  is_cmd_q;
    logic                  is_rd_q;
    logic [7:0]            addr_q;
    shp_pkg::shp_phase_type phase_q;
    logic [31:0]           status_q;
    logic [31:0]           mask_q;
    logic [3:0]            gpio_q;

    // Decode from synchronised pins only; stage 0 feeds stage 1 alone
    wire        cs_act   = ~csn_q[1];
    wire        cs_start = cs_act & ~act_q;
    wire        rise     = sclk_q[1] & ~sclk_q[2];
    wire        fall     = ~sclk_q[1] & sclk_q[2];
    wire        is_fifo  = (addr_q == `SHP_FIFO_ADDR);
    wire [7:0]  mask_off = addr_q - `SHP_MASK_BASE;
    wire [7:0]  stat_off = addr_q - `SHP_STATUS_BASE;
    wire        hit_mask = (mask_off < `SHP_IRQ_BYTES);
    wire        hit_stat = (stat_off < `SHP_IRQ_BYTES);
    wire        internal = hit_mask | hit_stat | is_fifo;
    wire [4:0]  mask_sh  = {~mask_off[1:0], 3'h0};
    wire [4:0]  stat_sh  = {~stat_off[1:0], 3'h0};
    wire [7:0]  mask_byte = 8'(mask_q >> mask_sh);
    wire [7:0]  stat_byte = 8'(status_q >> stat_sh);
    wire        in_data  = done_q & (phase_q == shp_pkg::SHP_PH_DATA);
    wire        wr_fire  = in_data & ~is_rd_q;
    wire        rd_start = done_q & ~is_cmd_q & is_rd_q & (phase_q != shp_pkg::SHP_PH_HEADER);
    wire [7:0]  step     = is_fifo ? `SHP_BYTE_ZERO : `SHP_ADDR_STEP;
    wire [7:0]  rd_data  = is_fifo ? rx_fifo_rdata_i : hit_mask ? mask_byte :
                           hit_stat ? stat_byte : reg_rdata_i;
    wire [31:0] clr_w    = (fetch_q & hit_stat) ? (32'h0000_00FF << stat_sh) : 32'h0;
    wire [31:0] mask_wr  = (wr_fire & hit_mask) ? (32'h0000_00FF << mask_sh) : 32'h0;
    wire [31:0] status_d = (status_q & ~clr_w) | (irq_event_i & `SHP_IRQ_VALID);
    wire        pending  = |(status_q & mask_q);

    // Sampling only, no gating, so the port keeps working in low-power states
    always_ff @(posedge core_clk_i or posedge reset_i) begin // see R12
        if (reset_i) begin
            sclk_q <= 3'h0;
            csn_q  <= 2'h3;
            mosi_q <= 2'h0;
            act_q  <= 1'b0;
        end else begin
            sclk_q <= {sclk_q[1:0], spi_sclk_i};
            csn_q  <= {csn_q[0], spi_chip_select_low_i};
            mosi_q <= {mosi_q[0], spi_mosi_i};
            act_q  <= cs_act;
        end
    end

    // Shift in on rising edges, MSB first
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            bit_q  <= 3'h0;
            rx_q   <= 8'h00;
            done_q <= 1'b0;
        end else begin
            done_q <= cs_act & rise & (bit_q == `SHP_BIT_LAST);
            if (!cs_act) begin
                bit_q <= 3'h0;
            end else if (rise) begin // see R2
                bit_q <= bit_q + 3'h1;
                rx_q  <= {rx_q[6:0], mosi_q[1]}; // see R4
            end
        end
    end

    // Output changes on falling edges; next byte enters at a byte boundary
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            tx_q          <= 8'h00;
            spi_miso_oe_o <= 1'b0;
        end else begin
            spi_miso_oe_o <= cs_act; // see R3
            if (cs_start) begin
                tx_q <= device_state_status_i[15:8]; // see R8
            end else if (cs_act && fall) begin // see R2
                tx_q <= (bit_q == 3'h0) ? next_q : {tx_q[6:0], 1'b0}; // see R4
            end
        end
    end
    assign spi_miso_o = tx_q[7];

    // Transaction sequencing
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            phase_q     <= shp_pkg::SHP_PH_HEADER;
            is_cmd_q    <= 1'b0;
            is_rd_q     <= 1'b0;
            addr_q      <= 8'h00;
            next_q      <= 8'h00;
            fetch_q     <= 1'b0;
            wr_step_q   <= 1'b0;
            cmd_code_o  <= 8'h00;
            cmd_valid_o <= 1'b0;
            reg_wdata_o <= 8'h00;
            reg_wr_o    <= 1'b0;
            reg_rd_o    <= 1'b0;
            tx_fifo_wr_o <= 1'b0;
            rx_fifo_rd_o <= 1'b0;
        end else begin
            cmd_valid_o  <= 1'b0;
            reg_wr_o     <= wr_fire & ~internal;
            tx_fifo_wr_o <= wr_fire & is_fifo; // see R11
            reg_rd_o     <= fetch_q & ~internal;
            rx_fifo_rd_o <= fetch_q & is_fifo; // see R11
            fetch_q      <= rd_start;
            wr_step_q    <= wr_fire;
            if (wr_fire) begin
                reg_wdata_o <= rx_q;
            end
            if (!cs_act) begin
                phase_q <= shp_pkg::SHP_PH_HEADER;
            end else if (done_q) begin
                case (phase_q)
                    shp_pkg::SHP_PH_HEADER: begin
                        is_cmd_q <= rx_q[`SHP_HDR_TYPE_BIT]; // see R5
                        is_rd_q  <= rx_q[`SHP_HDR_DIR_BIT]; // see R6
                        next_q   <= device_state_status_i[7:0]; // see R8
                        phase_q  <= shp_pkg::SHP_PH_ADDR;
                    end
                    shp_pkg::SHP_PH_ADDR: begin
                        next_q <= `SHP_BYTE_ZERO;
                        if (is_cmd_q) begin // see R5
                            cmd_code_o  <= rx_q;
                            cmd_valid_o <= 1'b1;
                            phase_q     <= shp_pkg::SHP_PH_DONE;
                        end else begin
                            addr_q  <= rx_q;
                            phase_q <= shp_pkg::SHP_PH_DATA;
                        end
                    end
                    shp_pkg::SHP_PH_DATA: begin
                        if (!is_rd_q) begin
                            next_q <= `SHP_BYTE_ZERO;
                        end
                    end
                    default: begin
                        next_q <= `SHP_BYTE_ZERO;
                    end
                endcase
            end
            // FIFO address does not step, so a burst walks FIFO bytes
            if (fetch_q) begin // see R10
                next_q <= rd_data;
                addr_q <= addr_q + step; // see R9
            end
            // Step only after the write pulse, so the address stands with it
            if (wr_step_q) begin
                addr_q <= addr_q + step; // see R9
            end
        end
    end
    assign reg_addr_o = addr_q;

    // Interrupt status and mask; an event in the clearing cycle survives
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            status_q <= `SHP_IRQ_RESET;
            mask_q   <= `SHP_MASK_RESET;
        end else begin
            status_q <= status_d; // see R14 R15 R16 R17 R18 R19 R21 R25
            mask_q   <= ((mask_q & ~mask_wr) | ({4{rx_q}} & mask_wr)) & `SHP_IRQ_VALID;
        end
    end

    // Each pin whose selection is zero carries the active-low request
    genvar g;
    for (g = 0; g < `SHP_GPIO_COUNT; g++) begin : g_pin
        always_ff @(posedge core_clk_i or posedge reset_i) begin
            if (reset_i) begin
                gpio_q[g] <= 1'b1;
            end else begin
                gpio_q[g] <= ~(pending & (gpio_sel_i[g*5 +: 5] == `SHP_GPIO_SEL_IRQ)); // see R20 R22 R23 R24
            end
        end
    end
    assign gpio_o = gpio_q;

    property p_miso_hiz;
        @(posedge core_clk_i) disable iff (reset_i) !cs_act |=> !spi_miso_oe_o;
    endproperty
    a_miso_hiz: assert property (p_miso_hiz) else $error("MISO driven while deselected"); // see R3

    property p_status_first;
        @(posedge core_clk_i) disable iff (reset_i) cs_start |=> tx_q == $past(device_state_status_i[15:8]);
    endproperty
    a_status_first: assert property (p_status_first) else $error("status byte not loaded"); // see R8

    property p_event_sets;
        @(posedge core_clk_i) disable iff (reset_i)
            1 |=> (status_q & $past(irq_event_i & `SHP_IRQ_VALID)) == $past(irq_event_i & `SHP_IRQ_VALID);
    endproperty
    a_event_sets: assert property (p_event_sets) else $error("event lost"); // see R21

    property p_sticky;
        @(posedge core_clk_i) disable iff (reset_i) 1 |=> (($past(status_q) & ~$past(clr_w)) & ~status_q) == 32'h0;
    endproperty
    a_sticky: assert property (p_sticky) else $error("status bit dropped"); // see R25

    property p_read_clears;
        @(posedge core_clk_i) disable iff (reset_i)
            (clr_w != 32'h0) && ((irq_event_i & clr_w) == 32'h0) |=> (status_q & $past(clr_w)) == 32'h0;
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("read did not clear"); // see R21

    property p_irq_pin;
        @(posedge core_clk_i) disable iff (reset_i)
            pending && gpio_sel_i[4:0] == `SHP_GPIO_SEL_IRQ |=> !gpio_o[0];
    endproperty
    a_irq_pin: assert property (p_irq_pin) else $error("request missing"); // see R24

    property p_masked_quiet;
        @(posedge core_clk_i) disable iff (reset_i) !pending |=> gpio_o == 4'hF;
    endproperty
    a_masked_quiet: assert property (p_masked_quiet) else $error("masked request seen"); // see R22

    property p_cmd_pulse;
        @(posedge core_clk_i) disable iff (reset_i) cmd_valid_o |=> !cmd_valid_o;
    endproperty
    a_cmd_pulse: assert property (p_cmd_pulse) else $error("command pulse too long"); // see R5

    property p_fifo_write;
        @(posedge core_clk_i) disable iff (reset_i) wr_fire && is_fifo |=> tx_fifo_wr_o && !reg_wr_o && is_fifo;
    endproperty
    a_fifo_write: assert property (p_fifo_write) else $error("FIFO write misrouted"); // see R10

    property p_burst_inc;
        @(posedge core_clk_i) disable iff (reset_i)
            wr_fire && !is_fifo |=> addr_q == $past(addr_q) ##1 addr_q == $past(addr_q, 2) + 8'h01;
    endproperty
    a_burst_inc: assert property (p_burst_inc) else $error("address not stepped"); // see R9

    c_cmd: cover property (@(posedge core_clk_i) disable iff (reset_i) cmd_valid_o);
    c_fifo_wr: cover property (@(posedge core_clk_i) disable iff (reset_i) tx_fifo_wr_o ##[1:200] tx_fifo_wr_o);
    c_burst_rd: cover property (@(posedge core_clk_i) disable iff (reset_i) reg_rd_o ##[1:200] reg_rd_o);
    c_irq: cover property (@(posedge core_clk_i) disable iff (reset_i) !gpio_o[0]);

endmodule

// ==== testbench/shp_host_model.sv ====
// Purpose: Host side of the serial link, a master that runs whole frames
// Assumes: Link clock period of 125 ns, well under the 10 MHz ceiling
// Notes:   The clock stands low between frames; the data line is inverted once on release
`timescale 1ns/1ps
module shp_host_model (
    // Serial pins
    output logic            spi_sclk_o,
    output logic            spi_chip_select_low_o,
    output logic            spi_mosi_o,
    input  wire logic       spi_miso_i
);
    initial begin
        spi_sclk_o            = 1'b0;
        spi_chip_select_low_o = 1'b1;
        spi_mosi_o            = 1'b0;
    end

    // One frame: select, setup gap, then every byte in order
    task automatic xfer(input logic [7:0] tx [$], output logic [7:0] rx [$]);
        logic [7:0] b;
        rx = {};
        spi_chip_select_low_o <= 1'b0;
        #2000;
        foreach (tx[i]) begin
            for (int k = 7; k >= 0; k--) begin
                spi_mosi_o <= tx[i][k];
                #62.5 spi_sclk_o <= 1'b1;
                b[k] = spi_miso_i;
                #62.5 spi_sclk_o <= 1'b0;
            end
            rx.push_back(b);
        end
        #200 spi_chip_select_low_o <= 1'b1;
        // Released data line must not keep showing the last bit
        spi_mosi_o <= ~spi_mosi_o;
        #500;
    endtask
endmodule

// ==== testbench/test_shp_spi_host_port.sv ====
// Purpose: Scenario bench of the SPI host port
// Assumes: Register data is the address XOR 5A; RX FIFO head counts from 40
// Notes:   Each scenario runs whole frames through the host model
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("mismatch %s expected %h seen %h", n, e, g); end end
module test_shp_spi_host_port;
    logic        core_clk   = 1'b0;
    logic        reset      = 1'b1;
    logic        sclk;
    logic        chip_select_low;
    logic        mosi;
    logic        miso;
    logic        miso_oe;
    logic [7:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  rx_head    = 8'h40;
    logic        tx_fifo_wr;
    logic        rx_fifo_rd;
    logic [7:0]  cmd_code;
    logic        cmd_valid;
    logic [31:0] irq_event  = 32'h0000_0000;
    logic [3:0]  gpio;
    logic [15:0] wr_q [$];
    logic [7:0]  tx_q [$];
    logic [7:0]  cmd_q [$];
    int          mismatches = 0;
    int          num_checks = 0;
    int          cycles     = 0;
    int          rd_count   = 0;
    wire  [7:0]  reg_rdata  = reg_addr ^ 8'h5A;

    always #5 core_clk = ~core_clk;

    // Undriven line shows the inverse, so a late or missing enable is seen
    shp_host_model HOST (.spi_sclk_o(sclk), .spi_chip_select_low_o(chip_select_low),
        .spi_mosi_o(mosi), .spi_miso_i(miso_oe ? miso : ~miso));

    shp_spi_host_port DUT (.core_clk_i(core_clk), .reset_i(reset), .spi_sclk_i(sclk),
        .spi_chip_select_low_i(chip_select_low), .spi_mosi_i(mosi), .spi_miso_o(miso),
        .spi_miso_oe_o(miso_oe), .device_state_status_i(16'hC35A), .reg_addr_o(reg_addr),
        .reg_wdata_o(reg_wdata), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_rdata_i(reg_rdata),
        .tx_fifo_wr_o(tx_fifo_wr), .rx_fifo_rd_o(rx_fifo_rd), .rx_fifo_rdata_i(rx_head),
        .cmd_code_o(cmd_code), .cmd_valid_o(cmd_valid), .irq_event_i(irq_event),
        .gpio_sel_i(20'h0_8420), .gpio_o(gpio));

    always @(posedge core_clk) begin
        cycles++;
        if (reg_wr) wr_q.push_back({reg_addr, reg_wdata});
        if (reg_rd) rd_count++;
        if (tx_fifo_wr) tx_q.push_back(reg_wdata);
        if (cmd_valid) cmd_q.push_back(cmd_code);
        if (rx_fifo_rd) rx_head <= rx_head + 8'h01;
        if (cycles == 20000) begin
            mismatches++;
            conclude();
        end
    end

    task automatic done(input string n);
        $display("test %s finished, mismatches so far %0d", n, mismatches);
        wr_q = {};
        tx_q = {};
        cmd_q = {};
        rd_count = 0;
    endtask

    task automatic pulse(input logic [31:0] v);
        @(posedge core_clk) irq_event <= v;
        @(posedge core_clk) irq_event <= 32'h0000_0000;
        repeat (4) @(posedge core_clk);
        #1;
    endtask

    task automatic t_reg_write();
        logic [7:0] rx [$];
        HOST.xfer('{8'h00, 8'h10, 8'h12, 8'h34}, rx);
        `CHK("status high", 8'hC3, rx[0])
        `CHK("status low", 8'h5A, rx[1])
        `CHK("write count", 2, wr_q.size())
        `CHK("write 0", 16'h1012, wr_q[0])
        `CHK("write 1", 16'h1134, wr_q[1])
        `CHK("idle enable", 1'b0, miso_oe)
        done("reg_write");
    endtask

    task automatic t_reg_read();
        logic [7:0] rx [$];
        HOST.xfer('{8'h01, 8'h20, 8'h00, 8'h00}, rx);
        `CHK("read 0", 8'h7A, rx[2])
        `CHK("read 1", 8'h7B, rx[3])
        `CHK("no write", 0, wr_q.size())
        `CHK("read pulses", 3, rd_count)
        done("reg_read");
    endtask

    task automatic t_fifo();
        logic [7:0] rx [$];
        HOST.xfer('{8'h00, 8'hFF, 8'hA1, 8'hA2}, rx);
        `CHK("tx count", 2, tx_q.size())
        `CHK("tx 0", 8'hA1, tx_q[0])
        `CHK("tx 1", 8'hA2, tx_q[1])
        `CHK("fifo not reg", 0, wr_q.size())
        HOST.xfer('{8'h01, 8'hFF, 8'h00, 8'h00}, rx);
        `CHK("rx 0", 8'h40, rx[2])
        `CHK("rx 1", 8'h41, rx[3])
        `CHK("pop count", 8'h43, rx_head)
        done("fifo");
    endtask

    task automatic t_command();
        logic [7:0] rx [$];
        HOST.xfer('{8'h80, 8'h63}, rx);
        `CHK("cmd count", 1, cmd_q.size())
        `CHK("cmd code", 8'h63, cmd_q[0])
        `CHK("cmd status", 8'h5A, rx[1])
        `CHK("cmd no write", 0, wr_q.size())
        done("command");
    endtask

    task automatic t_irq();
        logic [7:0] rx [$];
        HOST.xfer('{8'h00, 8'h93, 8'h01}, rx);
        pulse(32'h0000_0002);
        `CHK("masked pin", 4'hF, gpio)
        pulse(32'h0000_0001);
        `CHK("request pin", 4'hE, gpio)
        repeat (20) @(posedge core_clk);
        `CHK("held pin", 4'hE, gpio)
        HOST.xfer('{8'h01, 8'hFD, 8'h00}, rx);
        `CHK("status bits", 8'h03, rx[2])
        `CHK("released pin", 4'hF, gpio)
        HOST.xfer('{8'h01, 8'hFD, 8'h00}, rx);
        `CHK("cleared bits", 8'h00, rx[2])
        pulse(32'h7FC0_0000);
        HOST.xfer('{8'h01, 8'hFA, 8'h00, 8'h00}, rx);
        `CHK("top byte", 8'h60, rx[2])
        `CHK("gap bits", 8'h00, rx[3])
        `CHK("other masked", 4'hF, gpio)
        done("irq");
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge core_clk);
        reset <= 1'b0;
        repeat (4) @(posedge core_clk);
        `CHK("reset pin", 4'hF, gpio)
        t_reg_write();
        t_reg_read();
        t_fifo();
        t_command();
        t_irq();
        conclude();
    end
endmodule
